/* File: include/cecc_defs.svh */
`ifndef CECC_DEFS_SVH
`define CECC_DEFS_SVH

// ==========================================================
// Register indices; byte address is four times the index
`define CECC_ENABLE_IDX 8'hb0
`define CECC_OPTIONS_IDX 8'hb1

// ==========================================================
// Field positions
`define CECC_CONV1_BIT 0
`define CECC_CONV3_BIT 2
`define CECC_CLKSTOP_BIT 15
`define CECC_TOSEL_LSB 12
`define CECC_TOSEL_MSB 13

// ==========================================================
// Reset values
`define CECC_ON_REQ_RST 3'h0
`define CECC_CLKSTOP_RST 1'h0
`define CECC_TOSEL_RST 2'h0

// ==========================================================
// Timing
`define CECC_CLK_KHZ 10000.0
`define CECC_TO_CODE0_MS 0.5
`define CECC_TO_CODE1_MS 2.0
`define CECC_TO_CODE2_MS 32.0
`define CECC_TO_CODE3_MS 256.0
`define CECC_AHB_WORD 3'h2

`endif

/* File: include/cecc_pkg.sv */
`default_nettype none

package cecc_pkg;

    typedef enum logic [1:0]
    {
        CECC_SEL_NONE,
        CECC_SEL_ENABLE,
        CECC_SEL_OPTIONS
    } cecc_sel_t;

    typedef struct packed
    {
        logic [2:0] on_req;
        logic clk_stop;
        logic [1:0] to_sel;
        logic [21:0] to_cycles;
        logic [31:0] rdata;
    } cecc_regs_t;

    typedef struct packed
    {
        logic wr_pend;
        cecc_sel_t wr_sel;
    } cecc_bus_t;

endpackage : cecc_pkg

`default_nettype wire

/* File: rtl/cecc_ahb_slave.sv */
`include "cecc_defs.svh"
`default_nettype none

module cecc_ahb_slave
    import cecc_pkg::*;
(
    input wire logic clk, // 10 MHz clock
    input wire logic reset_n, // Async reset
    input wire logic ce, // Clock enable
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write flag
    input wire logic [2:0] hsize, // Transfer size
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    output logic wr_en, // Data phase write
    output cecc_sel_t wr_sel, // Write target
    output logic rd_en, // Read address phase
    output cecc_sel_t rd_sel // Read target
);

    // ==========================================================
    // Address decode
    function automatic cecc_sel_t cecc_decode(input logic [31:0] a);
        if (a == {22'h0, `CECC_ENABLE_IDX, 2'b00})
            return CECC_SEL_ENABLE;
        else if (a == {22'h0, `CECC_OPTIONS_IDX, 2'b00})
            return CECC_SEL_OPTIONS;
        else
            return CECC_SEL_NONE;
    endfunction : cecc_decode

    cecc_bus_t st;
    cecc_bus_t next_st;
    logic take;

    // Stalling on ce keeps the bus in step with the frozen state
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign take = hsel && htrans[1] && hready;
    assign wr_en = st.wr_pend && ce;
    assign wr_sel = st.wr_sel;
    assign rd_en = take && !hwrite;
    assign rd_sel = cecc_decode(haddr);

    always_comb
    begin
        next_st = st;
        if (ce && hready)
        begin
            // Only whole-word writes land; others are ignored
            next_st.wr_pend = take && hwrite && hsize == `CECC_AHB_WORD;
            next_st.wr_sel = cecc_decode(haddr);
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st <= '{wr_pend: 1'b0, wr_sel: CECC_SEL_NONE};
        else
            st <= next_st;
    end

endmodule : cecc_ahb_slave

`default_nettype wire

/* File: rtl/cecc_top.sv */
// Notes on behaviour
// - Enable bits 0..2 request converters 1..3 on when set, off when clear.
// - Enable request bits default to zero; power state machine restores that.
// - Options bit 15 set stops switching clocks of converters 1, 3, 4, 6.
// - Clock-stop bit returns to zero on power state machine reset.
// - Bits 13:12 pick shared power-up timeout; 00 is 0.5ms, 01 is 2ms.
//
// The implementer's own choice: the AHB-Lite register port.
`include "cecc_defs.svh"
`default_nettype none

module cecc_top
    import cecc_pkg::*;
#(
    parameter int unsigned TO0_CYCLES =
        int'(`CECC_TO_CODE0_MS * `CECC_CLK_KHZ),
    parameter int unsigned TO1_CYCLES =
        int'(`CECC_TO_CODE1_MS * `CECC_CLK_KHZ),
    parameter int unsigned TO2_CYCLES =
        int'(`CECC_TO_CODE2_MS * `CECC_CLK_KHZ),
    parameter int unsigned TO3_CYCLES =
        int'(`CECC_TO_CODE3_MS * `CECC_CLK_KHZ)
)
(
    input wire logic clk, // 10 MHz clock
    input wire logic reset_n, // Async reset
    input wire logic ce, // Clock enable
    input wire logic psm_reset, // State machine reset
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write flag
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic hresp, // Response
    output logic [31:0] hrdata, // Read data
    output logic [2:0] conv_on_request, // Converters 1..3
    output logic switcher_clock_stop, // Stop clocks 1,3,4,6
    output logic [1:0] powerup_timeout_select, // Timeout code
    output logic [21:0] powerup_timeout_cycles // Timeout length
);

    // ==========================================================
    // Timeout decode
    function automatic logic [21:0] cecc_timeout(input logic [1:0] code);
        case (code)
            2'h0: return TO0_CYCLES[21:0];
            2'h1: return TO1_CYCLES[21:0];
            2'h2: return TO2_CYCLES[21:0];
            default: return TO3_CYCLES[21:0];
        endcase
    endfunction : cecc_timeout

    function automatic logic [31:0] cecc_read(input cecc_sel_t sel,
                                              input cecc_regs_t r);
        logic [31:0] v;
        v = 32'h0;
        case (sel)
            CECC_SEL_ENABLE:
                v[`CECC_CONV3_BIT:`CECC_CONV1_BIT] = r.on_req;
            CECC_SEL_OPTIONS:
            begin
                v[`CECC_CLKSTOP_BIT] = r.clk_stop;
                v[`CECC_TOSEL_MSB:`CECC_TOSEL_LSB] = r.to_sel;
            end
            default: v = 32'h0;
        endcase
        return v;
    endfunction : cecc_read

    // ==========================================================
    // Bus slave
    logic wr_en;
    logic rd_en;
    cecc_sel_t wr_sel;
    cecc_sel_t rd_sel;

    cecc_ahb_slave u_bus
    (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr_en(wr_en),
        .wr_sel(wr_sel),
        .rd_en(rd_en),
        .rd_sel(rd_sel)
    );

    // ==========================================================
    // Register state
    cecc_regs_t st;
    cecc_regs_t next_st;

    always_comb
    begin
        next_st = st;
        if (ce)
        begin
            if (psm_reset)
            begin
                // Hardwired defaults; state machine reset beats a write
                next_st.on_req = `CECC_ON_REQ_RST;
                next_st.clk_stop = `CECC_CLKSTOP_RST;
                next_st.to_sel = `CECC_TOSEL_RST;
            end
            else if (wr_en)
            begin
                case (wr_sel)
                    CECC_SEL_ENABLE:
                        next_st.on_req =
                            hwdata[`CECC_CONV3_BIT:`CECC_CONV1_BIT];
                    CECC_SEL_OPTIONS:
                    begin
                        next_st.clk_stop = hwdata[`CECC_CLKSTOP_BIT];
                        next_st.to_sel =
                            hwdata[`CECC_TOSEL_MSB:`CECC_TOSEL_LSB];
                    end
                    default: next_st = st;
                endcase
            end
            next_st.to_cycles = cecc_timeout(next_st.to_sel);
            // Read from the post-write view so back-to-back access is exact
            if (rd_en)
                next_st.rdata = cecc_read(rd_sel, next_st);
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st.on_req <= `CECC_ON_REQ_RST;
            st.clk_stop <= `CECC_CLKSTOP_RST;
            st.to_sel <= `CECC_TOSEL_RST;
            st.to_cycles <= TO0_CYCLES[21:0];
            st.rdata <= 32'h0;
        end
        else
            st <= next_st;
    end

    // Requests only; the converter may still refuse to start
    assign conv_on_request = st.on_req;
    assign switcher_clock_stop = st.clk_stop;
    assign powerup_timeout_select = st.to_sel;
    assign powerup_timeout_cycles = st.to_cycles;
    assign hrdata = st.rdata;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_psm;
        ce && psm_reset;
    endsequence

    sequence s_wr_enable;
        ce && !psm_reset && wr_en && wr_sel == CECC_SEL_ENABLE;
    endsequence

    sequence s_wr_options;
        ce && !psm_reset && wr_en && wr_sel == CECC_SEL_OPTIONS;
    endsequence

    sequence s_rd_enable;
        ce && rd_en && rd_sel == CECC_SEL_ENABLE && !psm_reset && !wr_en;
    endsequence

    sequence s_rd_options;
        ce && rd_en && rd_sel == CECC_SEL_OPTIONS && !psm_reset && !wr_en;
    endsequence

    a_psm_clears_req: assert property
        (s_psm |=> conv_on_request == 3'h0)
        else $error("enable requests not cleared");

    a_psm_clears_stop: assert property
        (s_psm |=> !switcher_clock_stop)
        else $error("clock stop not cleared");

    // Length is decoded from the next code, so both move on one edge
    a_psm_clears_to: assert property
        (s_psm |=> powerup_timeout_select == 2'h0 &&
         powerup_timeout_cycles == 22'd5000)
        else $error("timeout select not cleared");

    a_req_write_lands: assert property
        (s_wr_enable |=> conv_on_request == $past(hwdata[2:0]))
        else $error("enable write lost");

    a_stop_write_lands: assert property
        (s_wr_options |=> switcher_clock_stop == $past(hwdata[15]) &&
         powerup_timeout_select == $past(hwdata[13:12]))
        else $error("options write lost");

    a_hold_no_write: assert property
        ((!ce || (!psm_reset && !wr_en)) |=>
         $stable(conv_on_request) && $stable(switcher_clock_stop) &&
         $stable(powerup_timeout_select))
        else $error("register changed without write");

    a_read_back_req: assert property
        (s_rd_enable |=> hrdata == {29'h0, conv_on_request})
        else $error("enable readback wrong");

    a_read_back_opt: assert property
        (s_rd_options |=> hrdata == {16'h0, switcher_clock_stop, 1'b0,
         powerup_timeout_select, 12'h0})
        else $error("options readback wrong");

    a_timeout_code1: assert property
        (powerup_timeout_select == 2'h1 |->
         powerup_timeout_cycles == 22'd20000)
        else $error("timeout length wrong");

endmodule : cecc_top

`default_nettype wire

/* File: verif/converter_enable_clock_control_bench.sv */
`include "cecc_defs.svh"
`default_nettype none

module converter_enable_clock_control_bench
    import cecc_pkg::*;
;
timeunit 1ns;
timeprecision 1ns;
// ==========================================
// Signals and expected register image
localparam logic [31:0] ENA = 32'(`CECC_ENABLE_IDX) << 2;
localparam logic [31:0] OPT = 32'(`CECC_OPTIONS_IDX) << 2;
localparam logic [2:0] WORD = 3'h2;
logic clk, reset_n, ce, psm_reset, hsel, hwrite, hreadyout, hresp;
logic [1:0] htrans, exp_to, powerup_timeout_select;
logic [2:0] hsize, exp_en, conv_on_request;
logic [31:0] haddr, hwdata, hrdata, rd, a, rnd;
logic exp_stop, switcher_clock_stop;
logic [21:0] powerup_timeout_cycles;
int mismatches, samples_checked, cycles;

cecc_top dut_u (.clk(clk), .reset_n(reset_n), .ce(ce),
    .psm_reset(psm_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .conv_on_request(conv_on_request),
    .switcher_clock_stop(switcher_clock_stop),
    .powerup_timeout_select(powerup_timeout_select),
    .powerup_timeout_cycles(powerup_timeout_cycles));

// ==========================================
// Expectations
function automatic logic [31:0] image(input logic [31:0] addr);
    if (addr == ENA)
        return {29'h0, exp_en};
    if (addr == OPT)
        return {16'h0, exp_stop, 1'b0, exp_to, 12'h0};
    return 32'h0;
endfunction : image

// Timeout lengths in 100 ns cycles
function automatic logic [21:0] to_len(input logic [1:0] code);
    case (code)
        2'h0: return 22'h001388;
        2'h1: return 22'h004e20;
        2'h2: return 22'h04e200;
        default: return 22'h271000;
    endcase
endfunction : to_len

// ==========================================
// Checking and bus tasks
task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
        mismatches++;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
endtask : chk

task automatic outs();
    chk("conv_on_request", conv_on_request, exp_en);
    chk("clock_stop", switcher_clock_stop, exp_stop);
    chk("timeout_select", powerup_timeout_select, exp_to);
    chk("hresp", hresp, 1'b0);
endtask : outs

// Entered right after a rising edge; holds each phase until hready
task automatic bus(input logic wr, input logic [31:0] addr,
    input logic [31:0] d, input logic [2:0] size);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= size;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    if (wr && size == WORD && addr == ENA)
        exp_en = d[2:0];
    if (wr && size == WORD && addr == OPT)
    begin
        exp_stop = d[15];
        exp_to = d[13:12];
    end
endtask : bus

task automatic wr(input logic [31:0] addr, input logic [31:0] d,
    input logic [2:0] size);
    bus(1'b1, addr, d, size);
    #1 outs();
    @(posedge clk);
    #1 chk("timeout_cycles", powerup_timeout_cycles, to_len(exp_to));
    @(posedge clk);
endtask : wr

task automatic rdchk(input logic [31:0] addr);
    bus(1'b0, addr, 32'h0, WORD);
    chk("read", rd, image(addr));
endtask : rdchk

task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask : test_done

// ==========================================
// Clock and hang guard
initial
begin
    clk = 1'b0;
    forever #50 clk = ~clk;
end

always @(posedge clk)
begin
    cycles++;
    // Tests need about 3300 cycles, most of it settle waits
    if (cycles == 8000)
    begin
        mismatches++;
        test_done();
    end
end

// ==========================================
// Main sequence
initial
begin
    reset_n = 1'b0; ce = 1'b1; psm_reset = 1'b0; hsel = 1'b0;
    haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = WORD;
    hwdata = 32'h0; exp_en = 3'h0; exp_stop = 1'b0; exp_to = 2'h0;
    void'($urandom(48230));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 outs();
    chk("timeout_cycles", powerup_timeout_cycles, to_len(2'h0));
    @(posedge clk);
    rdchk(ENA);
    rdchk(OPT);
    $display("reset test done");
    for (int c = 0; c < 4; c++)
        wr(OPT, 32'(c) << 12, WORD);
    $display("timeout code test done");
    // Converters taken as in regulator mode; settle before stopping
    repeat (1000) @(posedge clk);
    wr(OPT, 32'h00008000, WORD);
    wr(OPT, 32'h00000000, WORD);
    // Clocks must run this long before regulator mode is left
    repeat (1000) @(posedge clk);
    $display("clock stop test done");
    repeat (40)
    begin
        a = ($urandom % 2) ? ENA : OPT;
        rnd = $urandom;
        // Clock-stop bit kept: toggling it needs the settle waits
        if (a == OPT)
            rnd[`CECC_CLKSTOP_BIT] = exp_stop;
        wr(a, rnd, WORD);
        rdchk(a);
    end
    $display("random access test done");
    wr(ENA + 32'h8, 32'hffffffff, WORD);
    rdchk(ENA + 32'h8);
    wr(ENA, {29'h0, ~exp_en}, 3'h1);
    wr(OPT, 32'h0000b000, 3'h0);
    bus(1'b1, ENA, 32'h00000005, WORD);
    rdchk(ENA);
    $display("refused access test done");
    wr(ENA, 32'h00000007, WORD);
    repeat (1000) @(posedge clk);
    wr(OPT, 32'h0000b000, WORD);
    psm_reset <= 1'b1;
    @(posedge clk);
    psm_reset <= 1'b0;
    exp_en = 3'h0;
    exp_stop = 1'b0;
    exp_to = 2'h0;
    #1 outs();
    chk("timeout_cycles", powerup_timeout_cycles, to_len(2'h0));
    @(posedge clk);
    rdchk(ENA);
    rdchk(OPT);
    $display("state machine reset test done");
    wr(ENA, 32'h00000005, WORD);
    // A state machine reset while frozen must be held off
    ce <= 1'b0;
    psm_reset <= 1'b1;
    @(posedge clk);
    #1 chk("hreadyout", hreadyout, 1'b0);
    outs();
    @(posedge clk);
    ce <= 1'b1;
    psm_reset <= 1'b0;
    #1 outs();
    @(posedge clk);
    $display("clock enable test done");
    test_done();
end

endmodule : converter_enable_clock_control_bench

`default_nettype wire
